// [rtl/psc_defines.vh]
`ifndef PSC_DEFINES_VH
`define PSC_DEFINES_VH
// ----------------------------------------
// Register addresses (page bits on top)
// ----------------------------------------
`define PSC_A_PAGE 7'h00
`define PSC_A_EVT 9'h008
`define PSC_A_MASK 9'h00c
`define PSC_A_DOM 9'h00e
`define PSC_A_SYS 9'h00f
`define PSC_A_BOOT 9'h010
`define PSC_A_WD 9'h011
`define PSC_A_LOCK 9'h012
`define PSC_A_CMD 9'h013
`define PSC_A_PDD 9'h014
`define PSC_A_PIN 9'h015
`define PSC_LOCK_LO 9'h081
`define PSC_LOCK_HI 9'h120
`define PSC_LOCK_EXC 9'h100
// ----------------------------------------
// Field positions
// ----------------------------------------
`define PSC_F_STANDBY 3
`define PSC_F_SOFT 7
`define PSC_F_NFRZ 6:5
`define PSC_F_KEYSEL 4
`define PSC_F_RSTMODE 3
`define PSC_F_FRZEN 2
`define PSC_F_WDSLP 1
`define PSC_F_DEFSUP 7
`define PSC_F_SLEW 6:5
`define PSC_F_RELOAD 4
`define PSC_F_AUTO 3
`define PSC_F_DEB 2:0
`define PSC_F_SCALE 2:0
`define PSC_F_VLOCK 7
`define PSC_F_RTC 2
`define PSC_F_OFFRST 1
`define PSC_F_OFFSLP 0
`define PSC_F_CWAKE 2
`define PSC_F_CSHUT 1
`define PSC_F_CKICK 0
`define PSC_F_DPINS 7
`define PSC_F_D32K 6
`define PSC_F_DCHG 5
`define PSC_F_DCAL 4
`define PSC_F_DSER 2
`define PSC_F_DGPI 0
`define PSC_FN_WDOG 2'b00
`define PSC_FN_IN 2'b01
`define PSC_FN_OD 2'b10
`define PSC_RST_VAL 8'h00
// ----------------------------------------
// Timing
// ----------------------------------------
`define PSC_CLK_MHZ 10
`define PSC_DEB_TICK_NS 10000
`define PSC_DEB_T1 17'd10
`define PSC_DEB_T2 17'd100
`define PSC_DEB_T3 17'd1024
`define PSC_DEB_T4 17'd5120
`define PSC_DEB_T5 17'd25600
`define PSC_DEB_T6 17'd51200
`define PSC_DEB_T7 17'd102400
`define PSC_WD_BASE_US 2048000
`define PSC_DVC_NS0 4000
`define PSC_DVC_NS1 2000
`define PSC_DVC_NS2 1000
`define PSC_DVC_NS3 500
`endif

// [rtl/psc_sysctl.v]
`timescale 1ns/1ps
// How it works
// [RULE1] Five read/write masks for input events
// [RULE2] Domain targets written only where mask allows
// [RULE3] Power-down to slot 0 or partial pointer
// [RULE4] Slow-start bit drives converter soft start
// [RULE5] Restart limit blocks wake-ups after trials
// [RULE6] Key power-down normal or hold-delay governed
// [RULE7] Reset output follows sleep when mode set
// [RULE8] Watchdog runs in sleep only if enabled
// [RULE9] Slot 0 entry applies stored supply defaults
// [RULE10] DVC step interval chosen by slew field
// [RULE11] Reload supply config on leaving sleep
// [RULE12] Auto start or wait after reset
// [RULE13] Debounce inputs with selectable time
// [RULE14] Watchdog timeout doubles per scale step
// [RULE15] Lock blocks writes 0x81-0x120 except 0x100
// [RULE16] Real-time clock runs only when enabled
// [RULE17] Reset or sleep entry may kill everything
// [RULE18] Command bits pulse and clear themselves
// [RULE19] Sleep disables selected functions
// [RULE20] Pin wake enable per pin 0 and 1
// [RULE21] Pin polarity bit sets active level
// [RULE22] Pin function field selects pin role
// [RULE23] Event flag cleared by write-back, masked irq
// [RULE24] Page field supplies top address bits
// [RULE25] Reserved bits stored without effect
`include "psc_defines.vh"

module psc_sysctl #(
  parameter DEB_TICK_CYC = `PSC_DEB_TICK_NS * `PSC_CLK_MHZ / 1000,
  parameter WD_BASE_CYC = `PSC_WD_BASE_US * `PSC_CLK_MHZ
) (
  input wire core_clk,
  input wire rst,
  input wire [6:0] acc_addr,
  input wire acc_wr,
  input wire acc_rd,
  input wire [7:0] acc_wdata,
  output reg [7:0] acc_rdata_q,
  output reg ext_wr_q,
  output reg [8:0] ext_addr_q,
  output reg [7:0] ext_wdata_q,
  input wire [4:0] gpi_pin,
  input wire power_key_pin_n,
  input wire system_enable_pin,
  input wire reset_request_pin_n,
  input wire key_long_press,
  input wire key_hold_done,
  input wire sleep_state,
  input wire reset_state,
  input wire slot0_entry,
  input wire dvc_ramping,
  input wire [1:0] pin_drive_val,
  output reg [1:0] pin_o_q,
  output reg [1:0] pin_oe_q,
  output reg [7:0] debounced_q,
  output reg irq_req_q,
  output reg wake_req_q,
  output reg wake_block_q,
  output reg pd_req_q,
  output reg pd_partial_q,
  output reg reset_req_q,
  output reg dog_timeout_q,
  output reg reset_output_pin_n_q,
  output reg converter_soft_start_q,
  output reg key_sleep_state_select_q,
  output reg slot0_default_supplies_q,
  output reg reload_config_q,
  output reg start_up_q,
  output reg dvc_step_q,
  output reg all_off_q,
  output reg rtc_run_q,
  output reg [2:0] domain_en_q,
  output reg slow_clock_output_en_q,
  output reg charger_en_q,
  output reg calendar_en_q,
  output reg serial_en_q
);

// ----------------------------------------
// Register file
// ----------------------------------------
reg [7:0] page_q;
reg [4:0] evt_q;
reg [7:0] mask_q;
reg [7:0] dom_q;
reg [7:0] sys_q;
reg [7:0] boot_q;
reg [7:0] wd_q;
reg [7:0] lock_q;
reg [7:0] cmd_q;
reg [7:0] pdd_q;
reg [7:0] pin_q;
reg [1:0] trial_q;
reg [8:0] full_addr;
reg wr_ok;
reg in_bank;
reg [7:0] rd_d;
reg [4:0] evt_set;
reg wake_d;
wire [2:0] dom_wmask = acc_wdata[6:4];

function locked;
  input [8:0] a;
  input lk;
  begin
    locked = lk && (a >= `PSC_LOCK_LO) && (a <= `PSC_LOCK_HI) && (a != `PSC_LOCK_EXC);
  end
endfunction

function hit;
  input [8:0] a;
  input [8:0] b;
  begin
    hit = (a == b);
  end
endfunction

always @* begin
  full_addr = {page_q[1:0], acc_addr}; // RULE24
  wr_ok = acc_wr && !locked(full_addr, lock_q[`PSC_F_VLOCK]); // RULE15
  in_bank = (full_addr >= `PSC_A_EVT) && (full_addr <= `PSC_A_PIN);
  rd_d = 8'h00;
  if (acc_addr == `PSC_A_PAGE) rd_d = page_q;
  else if (hit(full_addr, `PSC_A_EVT)) rd_d = {3'b000, evt_q};
  else if (hit(full_addr, `PSC_A_MASK)) rd_d = mask_q;
  else if (hit(full_addr, `PSC_A_DOM)) rd_d = dom_q;
  else if (hit(full_addr, `PSC_A_SYS)) rd_d = sys_q;
  else if (hit(full_addr, `PSC_A_BOOT)) rd_d = boot_q;
  else if (hit(full_addr, `PSC_A_WD)) rd_d = wd_q;
  else if (hit(full_addr, `PSC_A_LOCK)) rd_d = lock_q;
  else if (hit(full_addr, `PSC_A_CMD)) rd_d = cmd_q;
  else if (hit(full_addr, `PSC_A_PDD)) rd_d = pdd_q;
  else if (hit(full_addr, `PSC_A_PIN)) rd_d = pin_q;
end

// Reserved bits are kept as written but drive nothing
always @(posedge core_clk) begin
  if (rst) begin
    page_q <= `PSC_RST_VAL;
    mask_q <= `PSC_RST_VAL;
    dom_q <= `PSC_RST_VAL;
    sys_q <= `PSC_RST_VAL;
    boot_q <= `PSC_RST_VAL;
    wd_q <= `PSC_RST_VAL;
    lock_q <= `PSC_RST_VAL;
    pdd_q <= `PSC_RST_VAL;
    pin_q <= `PSC_RST_VAL;
    cmd_q <= `PSC_RST_VAL;
    evt_q <= 5'h00;
    acc_rdata_q <= 8'h00;
    ext_wr_q <= 1'b0;
    ext_addr_q <= 9'h000;
    ext_wdata_q <= 8'h00;
  end else begin
    if (acc_rd) acc_rdata_q <= rd_d;
    ext_wr_q <= wr_ok && !in_bank && (acc_addr != `PSC_A_PAGE);
    ext_addr_q <= full_addr;
    ext_wdata_q <= acc_wdata;
    // Commands last one cycle; the read-back sees them clear
    cmd_q <= {cmd_q[7:3], 3'b000}; // RULE18
    // Set wins over the write-back clear
    evt_q <= (evt_q & ~((wr_ok && hit(full_addr, `PSC_A_EVT)) ?
      acc_wdata[4:0] : 5'h00)) | evt_set; // RULE23
    if (wr_ok) begin
      if (acc_addr == `PSC_A_PAGE) page_q <= acc_wdata;
      if (hit(full_addr, `PSC_A_MASK)) mask_q <= acc_wdata; // RULE1
      if (hit(full_addr, `PSC_A_DOM)) begin
        dom_q[7:3] <= acc_wdata[7:3];
        dom_q[2:0] <= (dom_q[2:0] & dom_wmask) | (acc_wdata[2:0] & ~dom_wmask); // RULE2
      end
      if (hit(full_addr, `PSC_A_SYS)) sys_q <= acc_wdata; // RULE25
      if (hit(full_addr, `PSC_A_BOOT)) boot_q <= acc_wdata;
      if (hit(full_addr, `PSC_A_WD)) wd_q <= acc_wdata;
      if (hit(full_addr, `PSC_A_LOCK)) lock_q <= acc_wdata;
      if (hit(full_addr, `PSC_A_CMD)) cmd_q <= acc_wdata; // RULE18
      if (hit(full_addr, `PSC_A_PDD)) pdd_q <= acc_wdata;
      if (hit(full_addr, `PSC_A_PIN)) pin_q <= acc_wdata;
    end
  end
end

// ----------------------------------------
// Input synchronise and debounce
// ----------------------------------------
wire [7:0] raw_in = {reset_request_pin_n, system_enable_pin, power_key_pin_n, gpi_pin};
reg [7:0] sync1_q;
reg [7:0] sync2_q;
reg [6:0] tick_cnt_q;
reg tick_q;

function [16:0] deb_len;
  input [2:0] code;
  begin
    case (code)
      3'd1: deb_len = `PSC_DEB_T1;
      3'd2: deb_len = `PSC_DEB_T2;
      3'd3: deb_len = `PSC_DEB_T3;
      3'd4: deb_len = `PSC_DEB_T4;
      3'd5: deb_len = `PSC_DEB_T5;
      3'd6: deb_len = `PSC_DEB_T6;
      default: deb_len = `PSC_DEB_T7;
    endcase
  end
endfunction

always @(posedge core_clk) begin
  if (rst) begin
    sync1_q <= 8'h00;
    sync2_q <= 8'h00;
    tick_cnt_q <= 7'h00;
    tick_q <= 1'b0;
  end else begin
    sync1_q <= raw_in;
    sync2_q <= sync1_q;
    tick_q <= (tick_cnt_q == DEB_TICK_CYC[6:0] - 7'h01);
    if (tick_cnt_q == DEB_TICK_CYC[6:0] - 7'h01) tick_cnt_q <= 7'h00;
    else tick_cnt_q <= tick_cnt_q + 7'h01;
  end
end

genvar gi;
generate
  for (gi = 0; gi < 8; gi = gi + 1) begin : g_deb
    reg [16:0] cnt_q;
    always @(posedge core_clk) begin
      if (rst) begin
        cnt_q <= 17'h00000;
        debounced_q[gi] <= 1'b0;
      end else if (boot_q[`PSC_F_DEB] == 3'b000) begin
        cnt_q <= 17'h00000;
        debounced_q[gi] <= sync2_q[gi];
      end else if (sync2_q[gi] == debounced_q[gi]) begin
        cnt_q <= 17'h00000;
      end else if (tick_q) begin
        // A level must hold for the whole time, any bounce restarts it
        if (cnt_q + 17'h00001 >= deb_len(boot_q[`PSC_F_DEB])) begin // RULE13
          cnt_q <= 17'h00000;
          debounced_q[gi] <= sync2_q[gi];
        end else begin
          cnt_q <= cnt_q + 17'h00001;
        end
      end
    end
  end
endgenerate

// ----------------------------------------
// Input events and wake-up
// ----------------------------------------
reg [4:0] act_prev_q;
reg [4:0] act;
reg [4:0] edge_v;
reg [4:0] is_in;
reg prev_sys_q;
reg prev_sysen_q;
reg prev_sleep_q;
reg prev_reset_q;
reg boot_wait_q;
reg kick;
wire [1:0] fn0 = pin_q[1:0];
wire [1:0] fn1 = pin_q[5:4];

always @* begin
  act = debounced_q[4:0];
  act[0] = debounced_q[0] ~^ pin_q[2]; // RULE21
  act[1] = debounced_q[1] ~^ pin_q[6]; // RULE21
  edge_v = act & ~act_prev_q;
  is_in = {3'b111, fn1 == `PSC_FN_IN, fn0 == `PSC_FN_IN}; // RULE22
  evt_set = edge_v & is_in & {5{!(sleep_state && pdd_q[`PSC_F_DGPI])}}; // RULE19
  wake_d = !wake_block_q && ((edge_v[0] && is_in[0] && !pin_q[3]) ||
    (edge_v[1] && is_in[1] && !pin_q[7]) || cmd_q[`PSC_F_CWAKE]); // RULE20
  kick = cmd_q[`PSC_F_CKICK] || (edge_v[0] && fn0 == `PSC_FN_WDOG); // RULE22
end

// ----------------------------------------
// Watchdog and restart limit
// ----------------------------------------
reg [24:0] wd_cnt_q;
reg [6:0] wd_mul_q;
reg [6:0] wd_len;
reg wd_run;
reg [5:0] dvc_cnt_q;
reg [5:0] dvc_len;
localparam integer DVC_CYC0 = `PSC_DVC_NS0 * `PSC_CLK_MHZ / 1000;
localparam integer DVC_CYC1 = `PSC_DVC_NS1 * `PSC_CLK_MHZ / 1000;
localparam integer DVC_CYC2 = `PSC_DVC_NS2 * `PSC_CLK_MHZ / 1000;
localparam integer DVC_CYC3 = `PSC_DVC_NS3 * `PSC_CLK_MHZ / 1000;

always @* begin
  wd_len = 7'h01 << (wd_q[`PSC_F_SCALE] - 3'd1); // RULE14
  wd_run = (wd_q[`PSC_F_SCALE] != 3'b000) && (!sleep_state || sys_q[`PSC_F_WDSLP]); // RULE8
  case (boot_q[`PSC_F_SLEW]) // RULE10
    2'b00: dvc_len = DVC_CYC0[5:0];
    2'b01: dvc_len = DVC_CYC1[5:0];
    2'b10: dvc_len = DVC_CYC2[5:0];
    default: dvc_len = DVC_CYC3[5:0];
  endcase
end

always @(posedge core_clk) begin
  if (rst) begin
    wd_cnt_q <= 25'h0000000;
    wd_mul_q <= 7'h00;
    dog_timeout_q <= 1'b0;
    trial_q <= 2'b00;
    wake_block_q <= 1'b0;
    dvc_cnt_q <= 6'h00;
    dvc_step_q <= 1'b0;
  end else begin
    dog_timeout_q <= 1'b0;
    dvc_step_q <= 1'b0;
    if (kick || !wd_run) begin
      wd_cnt_q <= 25'h0000000;
      wd_mul_q <= 7'h00;
    end else if (wd_cnt_q == WD_BASE_CYC[24:0] - 25'h0000001) begin
      wd_cnt_q <= 25'h0000000;
      if (wd_mul_q + 7'h01 >= wd_len) begin // RULE14
        wd_mul_q <= 7'h00;
        dog_timeout_q <= 1'b1;
        if (trial_q != 2'b11) trial_q <= trial_q + 2'b01; // RULE5
      end else begin
        wd_mul_q <= wd_mul_q + 7'h01;
      end
    end else begin
      wd_cnt_q <= wd_cnt_q + 25'h0000001;
    end
    // Limit counts timeouts since reset; only a reset clears it
    wake_block_q <= sys_q[`PSC_F_FRZEN] && (trial_q >= sys_q[`PSC_F_NFRZ]); // RULE5
    if (!dvc_ramping) begin
      dvc_cnt_q <= 6'h00;
    end else if (dvc_cnt_q == dvc_len - 6'h01) begin
      dvc_cnt_q <= 6'h00;
      dvc_step_q <= 1'b1; // RULE10
    end else begin
      dvc_cnt_q <= dvc_cnt_q + 6'h01;
    end
  end
end

// ----------------------------------------
// Power transitions and pin control
// ----------------------------------------
wire ent_sleep = sleep_state && !prev_sleep_q;
wire lv_sleep = !sleep_state && prev_sleep_q;
wire ent_reset = reset_state && !prev_reset_q;
wire lv_reset = !reset_state && prev_reset_q;

always @(posedge core_clk) begin
  if (rst) begin
    act_prev_q <= 5'h00;
    prev_sys_q <= 1'b0;
    prev_sysen_q <= 1'b0;
    prev_sleep_q <= 1'b0;
    prev_reset_q <= 1'b0;
    boot_wait_q <= 1'b0;
    irq_req_q <= 1'b0;
    wake_req_q <= 1'b0;
    pd_req_q <= 1'b0;
    pd_partial_q <= 1'b0;
    reset_req_q <= 1'b0;
    reset_output_pin_n_q <= 1'b1;
    converter_soft_start_q <= 1'b0;
    key_sleep_state_select_q <= 1'b0;
    slot0_default_supplies_q <= 1'b0;
    reload_config_q <= 1'b0;
    start_up_q <= 1'b0;
    all_off_q <= 1'b0;
    rtc_run_q <= 1'b0;
    domain_en_q <= 3'b000;
    slow_clock_output_en_q <= 1'b0;
    charger_en_q <= 1'b0;
    calendar_en_q <= 1'b0;
    serial_en_q <= 1'b0;
    pin_o_q <= 2'b00;
    pin_oe_q <= 2'b00;
  end else begin
    act_prev_q <= act;
    prev_sys_q <= dom_q[0];
    prev_sysen_q <= debounced_q[6];
    prev_sleep_q <= sleep_state;
    prev_reset_q <= reset_state;
    irq_req_q <= |(evt_q & ~mask_q[4:0]); // RULE23
    wake_req_q <= wake_d;
    pd_req_q <= (prev_sys_q && !dom_q[0]) || (prev_sysen_q && !debounced_q[6]) ||
      (sys_q[`PSC_F_KEYSEL] ? key_hold_done : key_long_press); // RULE3 RULE6
    pd_partial_q <= dom_q[`PSC_F_STANDBY]; // RULE3
    reset_req_q <= cmd_q[`PSC_F_CSHUT]; // RULE18
    key_sleep_state_select_q <= sys_q[`PSC_F_KEYSEL]; // RULE6
    if (!sys_q[`PSC_F_RSTMODE]) reset_output_pin_n_q <= 1'b1; // RULE7
    else if (ent_sleep) reset_output_pin_n_q <= 1'b0;
    else if (lv_sleep) reset_output_pin_n_q <= 1'b1;
    converter_soft_start_q <= sys_q[`PSC_F_SOFT]; // RULE4
    slot0_default_supplies_q <= slot0_entry && boot_q[`PSC_F_DEFSUP]; // RULE9
    reload_config_q <= lv_sleep && boot_q[`PSC_F_RELOAD]; // RULE11
    if (lv_reset && !boot_q[`PSC_F_AUTO]) boot_wait_q <= 1'b1; // RULE12
    else if (wake_d) boot_wait_q <= 1'b0;
    start_up_q <= (lv_reset && boot_q[`PSC_F_AUTO]) || (boot_wait_q && wake_d); // RULE12
    all_off_q <= (ent_reset && lock_q[`PSC_F_OFFRST]) ||
      (ent_sleep && lock_q[`PSC_F_OFFSLP]); // RULE17
    rtc_run_q <= lock_q[`PSC_F_RTC]; // RULE16
    domain_en_q <= dom_q[2:0] & {3{!(sleep_state && pdd_q[`PSC_F_DPINS])}}; // RULE19
    slow_clock_output_en_q <= !(sleep_state && pdd_q[`PSC_F_D32K]);
    charger_en_q <= !(sleep_state && pdd_q[`PSC_F_DCHG]);
    calendar_en_q <= lock_q[`PSC_F_RTC] && !(sleep_state && pdd_q[`PSC_F_DCAL]);
    serial_en_q <= !(sleep_state && pdd_q[`PSC_F_DSER]); // RULE19
    // Open drain only pulls low; push-pull drives both levels
    pin_o_q <= {fn1 == `PSC_FN_OD ? 1'b0 : pin_drive_val[1],
      fn0 == `PSC_FN_OD ? 1'b0 : pin_drive_val[0]}; // RULE22
    pin_oe_q <= {fn1[1] && (fn1[0] || !pin_drive_val[1]),
      fn0[1] && (fn0[0] || !pin_drive_val[0])}; // RULE22
  end
end

endmodule

// [tb/psc_sysctl_assertions.sv]
`timescale 1ns/1ps
module psc_sysctl_chk #(
  parameter DEB_TICK_CYC = 100,
  parameter WD_BASE_CYC = 20480000
) (
  input wire core_clk,
  input wire rst,
  input wire [6:0] acc_addr,
  input wire acc_wr,
  input wire acc_rd,
  input wire [7:0] acc_wdata,
  input wire [7:0] acc_rdata_q,
  input wire ext_wr_q,
  input wire [8:0] ext_addr_q,
  input wire [1:0] pin_drive_val,
  input wire [1:0] pin_o_q,
  input wire [1:0] pin_oe_q,
  input wire irq_req_q,
  input wire wake_req_q,
  input wire reset_req_q,
  input wire dog_timeout_q,
  input wire reset_output_pin_n_q,
  input wire converter_soft_start_q,
  input wire key_sleep_state_select_q,
  input wire pd_partial_q,
  input wire rtc_run_q
);
  // ----
  // Shadow of host writes
  // ----
  reg [1:0] pg_q;
  reg [2:0] calm_q;
  reg [7:0] sh_q [0:31];
  wire [8:0] fa = {pg_q, acc_addr};
  wire bank_wr = acc_wr && pg_q == 2'b00 && acc_addr < 7'h20;
  integer i;
  // Levels are only judged once writes have settled for three cycles
  always @(posedge core_clk) begin
    if (rst) begin
      pg_q <= 2'b00;
      calm_q <= 3'h0;
      for (i = 0; i < 32; i = i + 1) sh_q[i] <= 8'h00;
    end else begin
      if (acc_wr && acc_addr == 7'h00) pg_q <= acc_wdata[1:0];
      if (bank_wr) sh_q[acc_addr[4:0]] <= acc_wdata;
      calm_q <= acc_wr ? 3'h0 : (calm_q == 3'h7 ? calm_q : calm_q + 3'h1);
    end
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  // ----
  // Assertions
  // ----
  // Wake-ups may be blocked by the restart limit, so only judge it with the limit off
  cmd_wake_a: assert property (
    bank_wr && acc_addr == 7'h13 && acc_wdata[2] && !sh_q[15][2] |-> ##[1:2] wake_req_q)
    else $error("wake pulse missing");
  cmd_shut_a: assert property (
    bank_wr && acc_addr == 7'h13 && acc_wdata[1] |-> ##[1:2] reset_req_q)
    else $error("shutdown pulse missing");
  wake_pulse_a: assert property (wake_req_q |=> !wake_req_q)
    else $error("wake pulse too long");
  cmd_zero_a: assert property (
    acc_rd && fa == 9'h013 && calm_q >= 3'h3 |=> acc_rdata_q == 8'h00)
    else $error("command bits not cleared");
  mask_read_a: assert property (
    acc_rd && !acc_wr && fa == 9'h00c |=> acc_rdata_q == sh_q[12])
    else $error("mask readback wrong");
  irq_masked_a: assert property (
    calm_q >= 3'h3 && sh_q[12][4:0] == 5'h1f |-> !irq_req_q)
    else $error("masked event raised irq");
  lock_block_a: assert property (
    acc_wr && sh_q[18][7] && fa >= 9'h081 && fa <= 9'h120
    && fa != 9'h100 |=> !ext_wr_q)
    else $error("locked write passed");
  pass_write_a: assert property (
    acc_wr && acc_addr != 7'h00 && fa > 9'h120
    |=> ext_wr_q && ext_addr_q == $past(fa))
    else $error("paged write lost");
  cfg_levels_a: assert property (
    calm_q >= 3'h3 |-> converter_soft_start_q == sh_q[15][7]
    && key_sleep_state_select_q == sh_q[15][4] && pd_partial_q == sh_q[14][3]
    && rtc_run_q == sh_q[18][2])
    else $error("config level mismatch");
  rst_out_a: assert property (calm_q >= 3'h3 && !sh_q[15][3] |-> reset_output_pin_n_q)
    else $error("reset output asserted");
  no_dog_a: assert property (calm_q >= 3'h3 && sh_q[17][2:0] == 3'h0 |-> !dog_timeout_q)
    else $error("disabled watchdog fired");
  push_pull_a: assert property (
    calm_q >= 3'h3 && sh_q[21][1:0] == 2'b11
    |-> pin_oe_q[0] && pin_o_q[0] == $past(pin_drive_val[0]))
    else $error("push-pull pin wrong");
  open_drain_a: assert property (
    calm_q >= 3'h3 && sh_q[21][5:4] == 2'b10
    |-> !pin_o_q[1] && pin_oe_q[1] != $past(pin_drive_val[1]))
    else $error("open-drain pin wrong");
  cover property (wake_req_q);
  cover property (ext_wr_q);
  cover property (irq_req_q);
  cover property (dog_timeout_q);
endmodule

bind psc_sysctl psc_sysctl_chk #(.DEB_TICK_CYC(DEB_TICK_CYC), .WD_BASE_CYC(WD_BASE_CYC)) chk (
  .core_clk, .rst, .acc_addr, .acc_wr, .acc_rd, .acc_wdata, .acc_rdata_q, .ext_wr_q,
  .ext_addr_q, .pin_drive_val, .pin_o_q, .pin_oe_q, .irq_req_q, .wake_req_q, .reset_req_q,
  .dog_timeout_q, .reset_output_pin_n_q, .converter_soft_start_q, .key_sleep_state_select_q,
  .pd_partial_q, .rtc_run_q);

// [tb/psc_host.sv]
`timescale 1ns/1ps
module psc_host (
  input wire logic core_clk,
  output logic [6:0] acc_addr,
  output logic acc_wr,
  output logic acc_rd,
  output logic [7:0] acc_wdata,
  input wire logic [7:0] acc_rdata_q
);
  // ----
  // Byte transfers
  // ----
  logic [1:0] pg = 2'b00;
  initial begin
    acc_addr = 7'h00;
    acc_wr = 1'b0;
    acc_rd = 1'b0;
    acc_wdata = 8'h00;
  end
  // Idle address and data are scrambled so stale values never look valid
  task automatic put(input logic [6:0] a, input logic [7:0] d, input logic r);
    @(negedge core_clk);
    acc_addr = a;
    acc_wdata = d;
    acc_wr = !r;
    acc_rd = r;
    @(negedge core_clk);
    acc_wr = 1'b0;
    acc_rd = 1'b0;
    acc_addr = ~a;
    acc_wdata = ~d;
  endtask
  task automatic sel(input logic [8:0] a);
    if (a[8:7] != pg) begin
      pg = a[8:7];
      put(7'h00, {6'h00, pg}, 1'b0);
    end
  endtask
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    sel(a);
    put(a[6:0], d, 1'b0);
  endtask
  task automatic rd(input logic [8:0] a, output logic [7:0] d);
    sel(a);
    put(a[6:0], 8'h00, 1'b1);
    d = acc_rdata_q;
  endtask
endmodule

// [tb/tb.sv]
`timescale 1ns/1ps
module tb;
  localparam int WD = 20;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] gpi_pin = 5'h00;
  logic sleep_state = 1'b0;
  logic [1:0] pin_drive_val = 2'h0;
  logic system_enable_pin = 1'b0;
  logic reset_request_pin_n = 1'b1;
  logic dvc_ramping = 1'b0;
  logic reset_state = 1'b0;
  logic slot0_entry = 1'b0;
  logic wake_block_q, all_off_q, slot0_default_supplies_q, start_up_q;
  logic [7:0] ext_wdata_q;
  logic [2:0] domain_en_q;
  logic [6:0] acc_addr;
  logic acc_wr, acc_rd, ext_wr_q, irq_req_q, wake_req_q, reset_req_q, dog_timeout_q;
  logic reset_output_pin_n_q, converter_soft_start_q, key_sleep_state_select_q, pd_partial_q;
  logic rtc_run_q, slow_clock_output_en_q, charger_en_q, serial_en_q;
  logic [7:0] acc_wdata, acc_rdata_q, v;
  logic [8:0] ext_addr_q, a;
  logic [1:0] pin_o_q, pin_oe_q;
  wire [6:0] sleep_view = {slow_clock_output_en_q, charger_en_q, serial_en_q,
    reset_output_pin_n_q, domain_en_q};
  logic [31:0] lfsr = 32'h20;
  logic [7:0] m [0:511] = '{default: 8'h00};
  int regs[$] = '{'h00c, 'h00e, 'h00f, 'h010, 'h011, 'h012, 'h014, 'h015};
  logic [7:0] rsv[$] = '{8'he0, 8'h80, 8'h01, 8'h00, 8'hf8, 8'h78, 8'h0a, 8'h00};
  int lk[$] = '{'h081, 'h120, 'h121, 'h081};
  int errors = 0;
  int tests_run = 0;
  int cyc = 0;
  int r, k, n;
  always #50 core_clk = ~core_clk;
  psc_host host (.core_clk, .acc_addr, .acc_wr, .acc_rd, .acc_wdata, .acc_rdata_q);
  psc_sysctl #(.DEB_TICK_CYC(2), .WD_BASE_CYC(WD)) DUT (
    .core_clk, .rst, .acc_addr, .acc_wr, .acc_rd, .acc_wdata, .acc_rdata_q, .ext_wr_q,
    .ext_addr_q, .ext_wdata_q, .gpi_pin, .power_key_pin_n(1'b1), .system_enable_pin,
    .reset_request_pin_n, .key_long_press(1'b0), .key_hold_done(1'b0), .sleep_state,
    .reset_state, .slot0_entry, .dvc_ramping, .pin_drive_val, .pin_o_q,
    .pin_oe_q, .debounced_q(), .irq_req_q, .wake_req_q, .wake_block_q, .pd_req_q(),
    .pd_partial_q, .reset_req_q, .dog_timeout_q, .reset_output_pin_n_q,
    .converter_soft_start_q, .key_sleep_state_select_q, .slot0_default_supplies_q,
    .reload_config_q(), .start_up_q, .dvc_step_q(), .all_off_q, .rtc_run_q,
    .domain_en_q, .slow_clock_output_en_q, .charger_en_q, .calendar_en_q(), .serial_en_q);
  // ----
  // Helpers
  // ----
  function automatic logic [31:0] nxt(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rdc(input logic [8:0] ad, input logic [7:0] e);
    logic [7:0] d;
    host.rd(ad, d);
    check(d, e);
  endtask
  task automatic idle(input int c);
    repeat (c) @(negedge core_clk);
  endtask
  task give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      give_verdict;
    end
  end
  // ----
  // Scenarios
  // ----
  initial begin
    idle(6);
    rst = 1'b0;
    foreach (regs[k]) rdc(regs[k], 8'h00);
    // Reserved bits are kept clear, the host's side of the bargain
    for (r = 0; r < 3; r++) begin
      foreach (regs[k]) begin
        lfsr = nxt(lfsr);
        v = lfsr[7:0] & ~rsv[k];
        {pin_drive_val, dvc_ramping, system_enable_pin, reset_request_pin_n} = lfsr[12:8];
        a = regs[k];
        if (a == 9'h00e) m[a] = {v[7:3], (m[a][2:0] & v[6:4]) | (v[2:0] & ~v[6:4])};
        else m[a] = v;
        host.wr(a, v);
        rdc(a, m[a]);
      end
    end
    idle(3);
    check(converter_soft_start_q, m[15][7]);
    check(key_sleep_state_select_q, m[15][4]);
    check(pd_partial_q, m[14][3]);
    check(rtc_run_q, m[18][2]);
    rdc(9'h07f, 8'h00);
    // Random settings may have armed the restart limit, which would swallow the wake command
    host.wr(9'h00f, 8'h00);
    for (k = 1; k < 3; k++) begin
      host.wr(9'h013, 8'h01 << k);
      n = 0;
      while ((k == 2 ? wake_req_q : reset_req_q) !== 1'b1 && n < 8) begin
        idle(1);
        n++;
      end
      check(n < 5, 1'b1);
      idle(3);
      rdc(9'h013, 8'h00);
    end
    host.wr(9'h015, 8'h01);
    for (k = 1; k < 4; k++) begin
      host.wr(9'h013, 8'h01);
      host.wr(9'h011, k);
      host.wr(9'h013, 8'h01);
      n = 0;
      while (dog_timeout_q !== 1'b1 && n < 200) begin
        idle(1);
        n++;
      end
      check(n >= (WD << (k - 1)) - 2 && n <= (WD << (k - 1)) + 6, 1'b1);
    end
    // Three timeouts have been counted, so a limit of three must now block wake-ups
    host.wr(9'h00f, 8'h64);
    idle(2);
    check(wake_block_q, 1'b1);
    host.wr(9'h011, 8'h00);
    host.wr(9'h010, 8'h00);
    host.wr(9'h015, 8'h05);
    host.wr(9'h00c, 8'h00);
    host.wr(9'h008, 8'h1f);
    gpi_pin = 5'h11;
    idle(12);
    rdc(9'h008, 8'h11);
    check(irq_req_q, 1'b1);
    host.wr(9'h00c, 8'h1f);
    idle(3);
    check(irq_req_q, 1'b0);
    host.wr(9'h008, 8'h11);
    rdc(9'h008, 8'h00);
    host.wr(9'h015, 8'h01);
    gpi_pin = 5'h10;
    idle(12);
    rdc(9'h008, 8'h01);
    for (k = 0; k < 4; k++) begin
      host.wr(9'h015, k[1] ? 8'h33 : 8'h22);
      pin_drive_val = {2{k[0]}};
      idle(3);
      check({pin_oe_q, pin_o_q}, k[1] ? {2'b11, {2{k[0]}}} : {{2{~k[0]}}, 2'b00});
    end
    host.wr(9'h012, 8'h80);
    foreach (lk[k]) begin
      if (k == 3) host.wr(9'h012, 8'h00);
      host.wr(lk[k], 8'h5a);
      check(ext_wr_q, k > 1);
      if (k > 1) check(ext_addr_q, lk[k]);
      if (k > 1) check(ext_wdata_q, 8'h5a);
    end
    host.wr(9'h00f, 8'h08);
    host.wr(9'h014, 8'he4);
    sleep_state = 1'b1;
    idle(4);
    check(sleep_view, 7'h00);
    sleep_state = 1'b0;
    idle(4);
    check(sleep_view, {4'hf, m[14][2:0]});
    host.wr(9'h012, 8'h02);
    host.wr(9'h010, 8'h88);
    {reset_state, slot0_entry} = 2'b11;
    idle(1);
    check({all_off_q, slot0_default_supplies_q, start_up_q}, 3'b110);
    {reset_state, slot0_entry} = 2'b00;
    idle(1);
    check({all_off_q, slot0_default_supplies_q, start_up_q}, 3'b001);
    give_verdict;
  end
endmodule
